// *** rtl/bidir_port_change_irq.sv ***
// Eight-bit bidirectional port with shared pull-ups and change detection.
// Assumes pins are asynchronous to clock_in and software uses the plain
// register port: one-cycle strobes, read data the cycle after.
//
// How it works
// RULE1 - A direction bit of one releases that pin's driver.
// RULE2 - A direction bit of zero drives the output latch onto the pin.
// RULE3 - An enabled alternate function overrides direction and drive.
// RULE4 - Port reads return pin levels; writes only load the output latch.
// RULE5 - Writes store all eight latches, input pins included.
// RULE6 - Option bit 7 cleared enables all eight weak pull-ups.
// RULE7 - A pin set as output has its pull-up switched off.
// RULE8 - After reset every weak pull-up is disabled.
// RULE9 - Only upper four input pins take part in change detection.
// RULE10 - Mismatches against the last-read snapshot are ORed into flag bit 0.
// RULE11 - A change event produces a wake request for sleep mode.
// RULE12 - Any port read or write refreshes the comparison snapshot.
// RULE13 - A persisting mismatch keeps setting the flag despite clears.
// RULE14 - A pin change during a port read may miss the flag; here a mismatch in the read cycle still sets it.
// RULE15 - Low-voltage programming disables detection and pull-up on bit 4.
// RULE16 - Software should not poll the port while using change detection.
// RULE17 - Outside circuits must not fight a pin the device drives.
// RULE18 - Pins pass two flip-flops before reads and comparison.
// RULE19 - The flag sets in the cycle a mismatch is seen; set beats clear.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps

module bidir_port_change_irq
    import port_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    // Register port
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       write_in,
    input  wire logic       read_in,
    output logic      [7:0] rdata_out,
    // Pins
    input  wire logic [7:0] pin_in,
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe_out,
    output logic      [7:0] pullup_out,
    // Alternate functions and configuration
    input  wire logic [7:0] alt_enable_in,
    input  wire logic [7:0] alt_data_in,
    input  wire logic [7:0] alt_oe_in,
    input  wire logic       lowvolt_prog_enable_in,
    // Change event
    output logic            change_irq_flag_out,
    output logic            wake_out
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else begin
            pin_meta <= pin_in;   // RULE18
            pin_sync <= pin_meta;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] port_latch;
    logic [7:0] option_ctrl;
    logic [7:0] direction_ctrl;
    logic [7:0] snapshot;
    logic       change_irq_flag;
    logic [7:0] next_port_latch;
    logic [7:0] next_option_ctrl;
    logic [7:0] next_direction_ctrl;
    logic [7:0] next_snapshot;
    logic       next_change_irq_flag;
    logic [7:0] next_rdata;
    logic [7:0] watched;
    logic       mismatch;
    logic       port_access;

    always_comb begin
        // Output pins and pins on bit 4 under low-voltage programming drop out.
        watched = upper_four_mask & direction_ctrl;   // RULE9
        if (lowvolt_prog_enable_in) begin
            watched[pin_bit4] = 1'b0;   // RULE15
        end
    end

    // Comparing against the synchronised level means a change landing in the
    // same cycle as a port access still sets the flag as the snapshot refreshes.
    assign mismatch    = |((pin_sync ^ snapshot) & watched);   // RULE10 RULE14
    assign port_access = (write_in || read_in) && addr_in == port_data_addr;

    always_comb begin
        next_port_latch      = port_latch;
        next_option_ctrl     = option_ctrl;
        next_direction_ctrl  = direction_ctrl;
        next_snapshot        = snapshot;
        next_change_irq_flag = change_irq_flag;
        next_rdata           = 8'h00;
        if (port_access) begin
            next_snapshot = pin_sync;   // RULE12
        end
        if (write_in) begin
            unique case (addr_in)
                port_data_addr:      next_port_latch = wdata_in;   // RULE4 RULE5
                option_ctrl_addr:    next_option_ctrl = wdata_in;
                direction_ctrl_addr: next_direction_ctrl = wdata_in;
                irq_control_addr:    next_change_irq_flag = wdata_in[change_flag_bit];
                default:             ;
            endcase
        end
        if (read_in) begin
            unique case (addr_in)
                port_data_addr:      next_rdata = pin_sync;   // RULE4
                option_ctrl_addr:    next_rdata = option_ctrl;
                direction_ctrl_addr: next_rdata = direction_ctrl;
                irq_control_addr:    next_rdata = {7'h00, change_irq_flag};
                default:             next_rdata = 8'h00;
            endcase
        end
        if (mismatch) begin
            next_change_irq_flag = 1'b1;   // RULE13 RULE19
        end
    end

    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            port_latch      <= latch_reset;
            option_ctrl     <= option_reset;   // RULE8
            direction_ctrl  <= direction_reset;
            snapshot        <= 8'h00;
            change_irq_flag <= 1'b0;
            rdata_out       <= 8'h00;
        end else begin
            port_latch      <= next_port_latch;
            option_ctrl     <= next_option_ctrl;
            direction_ctrl  <= next_direction_ctrl;
            snapshot        <= next_snapshot;
            change_irq_flag <= next_change_irq_flag;
            rdata_out       <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers and pull-ups
    // ------------------------------------------------------------------
    logic [7:0] drive_en;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            drive_en[i] = alt_enable_in[i] ? alt_oe_in[i] : ~direction_ctrl[i];   // RULE1 RULE3
            pin_out[i]  = alt_enable_in[i] ? alt_data_in[i] : port_latch[i];   // RULE2
        end
        pin_oe_out = drive_en;
        // A driven pin never carries the pull-up, so no current is wasted.
        pullup_out = {8{~option_ctrl[pullup_enable_n_bit]}} & ~drive_en;   // RULE6 RULE7
        if (lowvolt_prog_enable_in) begin
            pullup_out[pin_bit4] = 1'b0;   // RULE15
        end
    end

    assign change_irq_flag_out = change_irq_flag;
    assign wake_out            = change_irq_flag;   // RULE11

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_flag_sets: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE10
        mismatch |=> change_irq_flag)
        else $error("mismatch did not set flag");
    chk_set_beats_clear: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE19
        (mismatch && write_in && addr_in == irq_control_addr && !wdata_in[0]) |=> change_irq_flag)
        else $error("clear beat simultaneous set");
    chk_snapshot_refresh: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE12
        port_access |=> snapshot == $past(pin_sync))
        else $error("snapshot not refreshed");
    chk_release_driver: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE1
        (direction_ctrl[0] && !alt_enable_in[0]) |-> !pin_oe_out[0])
        else $error("input pin driven");
    chk_drive_latch: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE2
        (!direction_ctrl[5] && !alt_enable_in[5]) |-> (pin_oe_out[5] && pin_out[5] == port_latch[5]))
        else $error("output pin not driving latch");
    chk_port_read: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE4
        (read_in && addr_in == port_data_addr) |=> rdata_out == $past(pin_sync))
        else $error("port read not pin level");
    chk_pullup_output: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE7
        (pin_oe_out != 8'h00) |-> (pullup_out & pin_oe_out) == 8'h00)
        else $error("pull-up on driven pin");
    chk_lowvolt_bit4: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE15
        lowvolt_prog_enable_in |-> !pullup_out[4] && !watched[4])
        else $error("bit 4 active under low-voltage programming");
    chk_lower_excluded: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE9
        (watched[3:0] == 4'h0) && ((watched & ~direction_ctrl) == 8'h00))
        else $error("wrong pins compared");
    chk_reset_pullups: assert property (@(posedge clock_in)   // RULE8
        $rose(rst_n) |-> pullup_out == 8'h00)
        else $error("pull-ups on after reset");
    chk_write_latch: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE5
        (write_in && addr_in == port_data_addr) |=> port_latch == $past(wdata_in))
        else $error("latch not written");

    // ------------------------------------------------------------------
    // Address decode for the register checks
    // ------------------------------------------------------------------
    function automatic logic hits(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // ------------------------------------------------------------------
    // Register and driver checks
    // ------------------------------------------------------------------
    // Read data must fall back to zero, or a stale value could be taken as fresh.
    chk_rdata_idle: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE4
        !read_in |=> rdata_out == 8'h00)
        else $error("read data not cleared");

    chk_option_read: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE6
        (read_in && hits(addr_in, option_ctrl_addr)) |=> rdata_out == $past(option_ctrl))
        else $error("option read wrong");

    chk_option_write: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE6
        (write_in && hits(addr_in, option_ctrl_addr)) |=> option_ctrl == $past(wdata_in))
        else $error("option not written");

    chk_pullup_on: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE6
        (!option_ctrl[pullup_enable_n_bit] && !pin_oe_out[6]) |-> pullup_out[6])
        else $error("pull-up missing on input pin");

    chk_pullup_off: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE6
        option_ctrl[pullup_enable_n_bit] |-> pullup_out == 8'h00)
        else $error("pull-up on while disabled");

    chk_alt_override: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE3
        alt_enable_in[3] |-> (pin_oe_out[3] == alt_oe_in[3] && pin_out[3] == alt_data_in[3]))
        else $error("alternate function not in control");

    chk_release_all: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE1
        (pin_oe_out & direction_ctrl & ~alt_enable_in) == 8'h00)
        else $error("input pin driven");

    chk_drive_all: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE2
        (~direction_ctrl & ~alt_enable_in & ~pin_oe_out) == 8'h00)
        else $error("output pin released");

    chk_direction_write: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE1
        (write_in && hits(addr_in, direction_ctrl_addr)) |=> direction_ctrl == $past(wdata_in))
        else $error("direction not written");

    chk_direction_read: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE1
        (read_in && hits(addr_in, direction_ctrl_addr)) |=> rdata_out == $past(direction_ctrl))
        else $error("direction read wrong");

    chk_latch_hold: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE5
        !(write_in && hits(addr_in, port_data_addr)) |=> port_latch == $past(port_latch))
        else $error("latch changed without write");

    chk_unmapped_read: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE4
        (read_in && !hits(addr_in, port_data_addr) && !hits(addr_in, option_ctrl_addr)
            && !hits(addr_in, direction_ctrl_addr) && !hits(addr_in, irq_control_addr)) |=> rdata_out == 8'h00)
        else $error("unmapped read not zero");

    // ------------------------------------------------------------------
    // Change detection checks
    // ------------------------------------------------------------------
    chk_sync_stage: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE18
        pin_sync == $past(pin_meta))
        else $error("synchroniser stage skipped");

    chk_snapshot_hold: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE12
        !port_access |=> snapshot == $past(snapshot))
        else $error("snapshot moved without access");

    // Without a mismatch or a write, the flag must neither rise nor fall.
    chk_flag_holds: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE13
        (!mismatch && !(write_in && hits(addr_in, irq_control_addr))) |=> change_irq_flag == $past(change_irq_flag))
        else $error("flag moved by itself");

    chk_flag_write: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE19
        (write_in && hits(addr_in, irq_control_addr) && !mismatch) |=> change_irq_flag == $past(wdata_in[0]))
        else $error("flag write lost");

    chk_irq_read: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE10
        (read_in && hits(addr_in, irq_control_addr)) |=> rdata_out == {7'h00, $past(change_irq_flag)})
        else $error("flag read wrong");

    chk_wake_flag: assert property (@(posedge clock_in) disable iff (!rst_n)   // RULE11
        wake_out == change_irq_flag)
        else $error("wake request does not follow flag");

endmodule

// *** rtl/port_pkg.sv ***
// Constants shared by the bidirectional port with change detection.
// Assumes a single core clock and the plain register port of the core.
package port_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] port_data_addr      = 8'h06;
    localparam logic [7:0] option_ctrl_addr    = 8'h81;
    localparam logic [7:0] direction_ctrl_addr = 8'h86;
    localparam logic [7:0] irq_control_addr    = 8'h0b;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         pullup_enable_n_bit = 7;
    localparam int         change_flag_bit     = 0;
    localparam int         pin_bit4            = 4;
    localparam logic [7:0] option_reset        = 8'hff;
    localparam logic [7:0] direction_reset     = 8'hff;
    localparam logic [7:0] latch_reset         = 8'h00;
    localparam logic [7:0] upper_four_mask     = 8'hf0;

endpackage

// *** verification/pin_model.sv ***
// Behavioural model of the board around the port pins.
// Assumes one clock; pin levels are resolved in zero time.
`timescale 1ns/1ps

module pin_model (
    // Clock
    input  wire logic       clock_in,
    // Device side
    input  wire logic [7:0] pin_out_in,
    input  wire logic [7:0] pin_oe_in,
    input  wire logic [7:0] pullup_in,
    // Board side
    input  wire logic [7:0] ext_en_in,
    input  wire logic [7:0] ext_val_in,
    output logic      [7:0] level_out
);
    logic [7:0] drift = 8'h55;

    // An open pin wanders, so a missing pull-up shows as noise.
    always @(posedge clock_in) drift <= ~drift;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_in[i]) level_out[i] = pin_out_in[i];
            else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
            else if (pullup_in[i]) level_out[i] = 1'b1;
            else level_out[i] = drift[i];
        end
    end
endmodule

// *** verification/bidir_port_change_irq_tb.sv ***
// Self-checking bench for the bidirectional port with change detection.
// Assumes the pin model on the far side and the plain register port.
`timescale 1ns/1ps

module bidir_port_change_irq_tb;
    import port_pkg::*;
    logic       clock_in = 0, nrst_in = 0, write_in = 0, read_in = 0, lowvolt_prog_enable = 0;
    logic [7:0] addr_in = 0, wdata_in = 0, rdata_out, pin_in, pin_out, pin_oe_out, pullup_out;
    logic [7:0] alt_en = 0, alt_dat = 0, alt_oe = 0, ext_en = 8'hff, ext_val = 8'h3c, d;
    logic       change_irq_flag_out, wake_out;
    int         err_count = 0, total_checks = 0, cycles = 0;

    always #20 clock_in = ~clock_in;

    bidir_port_change_irq u_bidir_port_change_irq (.clock_in(clock_in), .nrst_in(nrst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
        .rdata_out(rdata_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
        .pullup_out(pullup_out), .alt_enable_in(alt_en), .alt_data_in(alt_dat),
        .alt_oe_in(alt_oe), .lowvolt_prog_enable_in(lowvolt_prog_enable),
        .change_irq_flag_out(change_irq_flag_out), .wake_out(wake_out));
    pin_model u_pin_model (.clock_in(clock_in), .pin_out_in(pin_out), .pin_oe_in(pin_oe_out),
        .pullup_in(pullup_out), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_in));

    // ------------------------------------------------------------------
    // Bus cycles and comparison
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock_in);
        addr_in <= a; wdata_in <= v; write_in <= 1'b1;
        @(posedge clock_in);
        write_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock_in);
        addr_in <= a; read_in <= 1'b1;
        @(posedge clock_in);
        read_in <= 1'b0;
        #1 v = rdata_out;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        rd(option_ctrl_addr, d); chk(d, 8'hff);
        rd(direction_ctrl_addr, d); chk(d, 8'hff);
        rd(8'h40, d); chk(d, 8'h00);
        chk(pin_oe_out, 8'h00);
        chk(pullup_out, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_drive;
        wr(port_data_addr, 8'ha5);
        wr(direction_ctrl_addr, 8'h0f);
        idle(1); chk(pin_oe_out, 8'hf0);
        chk(pin_out, 8'ha5);
        idle(3); rd(port_data_addr, d); chk(d, 8'hac);
        wr(option_ctrl_addr, 8'h7f);
        idle(1); chk(pullup_out, 8'h0f);
        alt_en <= 8'h01; alt_oe <= 8'h01; alt_dat <= 8'h01;
        idle(1); chk({pin_oe_out[0], pin_out[0]}, 8'h03);
        alt_en <= 8'h00;
        $display("test drive done");
    endtask
    task automatic t_change;
        wr(direction_ctrl_addr, 8'hff);
        ext_en <= 8'h00;
        idle(4); rd(port_data_addr, d); chk(d, 8'hff);
        wr(irq_control_addr, 8'h00);
        idle(2); chk(change_irq_flag_out, 1'b0);
        ext_en <= 8'h01; ext_val <= 8'h00;
        idle(6); chk(change_irq_flag_out, 1'b0);
        // The port is left unread while a change is awaited.
        ext_en <= 8'h21;
        idle(4); chk({change_irq_flag_out, wake_out}, 8'h03);
        wr(irq_control_addr, 8'h00);
        idle(2); chk(change_irq_flag_out, 1'b1);
        rd(port_data_addr, d); chk(d, 8'hde);
        wr(irq_control_addr, 8'h00);
        idle(2); chk(change_irq_flag_out, 1'b0);
        lowvolt_prog_enable <= 1'b1;
        idle(1); chk(pullup_out, 8'hef);
        ext_en <= 8'h31;
        idle(6); chk(change_irq_flag_out, 1'b0);
        $display("test change done");
    endtask

    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        repeat (3) @(posedge clock_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        t_reset();
        t_drive();
        t_change();
        end_of_test();
    end
endmodule
